//--- verilog/mrp_pkg.sv
package mrp_pkg;
    // Interface select strap level that picks RMII
    localparam logic       IFACE_RMII      = 1'b1;
    localparam int         FIFO_DEPTH      = 16;
    // Receive word: err, symMsb, nibble[3:0]
    localparam int         WORD_W          = 6;
    localparam int         WORD_ERR        = 5;
    localparam int         WORD_SYM        = 4;
    // Start-of-frame delimiter byte
    localparam logic [7:0] SFD_BYTE        = 8'hAB;
    // Clock figures, Hz
    localparam int         SYS_CLK_HZ      = 40_000_000;
    localparam int         RXCLK_100_HZ    = 25_000_000;
    localparam int         RXCLK_10_HZ     = 2_500_000;
    // Half-period counts of the 10 Mb/s receive clock, derived and rounded down
    localparam int         HALF_10_CYC     = SYS_CLK_HZ / (2 * RXCLK_10_HZ);
    localparam logic [3:0] HALF_10         = 4'(HALF_10_CYC);
    localparam logic [3:0] HALF_100        = 4'h1;
    localparam logic [2:0] MODE_SYMBOL     = 3'h7;
    localparam logic [1:0] DIBIT_IDLE      = 2'h0;
    localparam logic [3:0] NIBBLE_IDLE     = 4'h0;
endpackage

//--- verilog/mrp_strap_latch.sv
`timescale 1ns/1ps
module mrp_strap_latch (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // Strap pins, raw
    input  wire logic [6:0] strapPins,
    // Captured values
    output logic      [6:0] strapVal,
    output logic            strapDone
);
    logic [6:0] sync1_q;
    logic [6:0] sync2_q;
    logic [6:0] val_q;
    logic       done_q;
    logic [1:0] settle_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= strapPins;
            sync2_q <= sync1_q;
        end
    end

    // Capture once after release, then hold until the next reset.
    // Two edges let the synchroniser fill first, so the capture never
    // takes its reset value for a strap level.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            settle_q <= '0;
            val_q    <= '0;
            done_q   <= 1'b0;
        end else begin
            settle_q <= {settle_q[0], 1'b1};
            if (settle_q[1] && !done_q) begin
                val_q  <= sync2_q;
                done_q <= 1'b1;
            end
        end
    end

    assign strapVal  = val_q;
    assign strapDone = done_q;
endmodule // mrp_strap_latch

//--- verilog/mrp_fifo.sv
`timescale 1ns/1ps
module mrp_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign inReady  = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outData  = mem[rdPtr_q];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // mrp_fifo

//--- verilog/mrp_rx_port.sv
// How it works
// - Nibbles go out on four data lines in MII, lowest two in RMII.
// - Data lines two and three are idle low in RMII.
// - Interface strap low selects MII, high selects RMII.
// - Management address is the three address straps together.
// - Default operating mode is the three mode straps together.
// - Receive error rises on any error in the current frame.
// - In MII, symbol mode drives the code-group MSB on the fifth data line.
// - Outside symbol mode the fifth data line is the error output.
// - MII sources a receive clock of 20 or 2.5 MHz per link speed.
// - Data valid only while decoded data sits on the lines.
// - MII collision output follows the detected collision.
// - RMII carrier/valid is high whenever the medium is not idle, except while own transmit is blocked in 10 Mb/s half duplex.
// - RMII 10 Mb/s holds data low until the delimiter byte arrives.
// - RMII 10 Mb/s half duplex never echoes own transmit data.
// - MII carrier sense follows the detected carrier.
// - Straps are captured at each reset and held until the next.
`timescale 1ns/1ps
module mrp_rx_port
    import mrp_pkg::*;
#(
    parameter int DEPTH = mrp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // Strap pins
    input  wire logic       iface_select_strap,
    input  wire logic       mgmt_addr_strap_bit0,
    input  wire logic       mgmt_addr_strap_bit1,
    input  wire logic       mgmt_addr_strap_bit2,
    input  wire logic       opmode_strap_bit0,
    input  wire logic       opmode_strap_bit1,
    input  wire logic       opmode_strap_bit2,
    // Link state from the decoder
    input  wire logic       linkSpeed100,
    input  wire logic       fullDuplex,
    input  wire logic       symbolMode,
    input  wire logic       txActive,
    input  wire logic       mediumActive,
    input  wire logic       carrierDet,
    input  wire logic       collisionDet,
    // Decoded receive stream
    input  wire logic       decValid,
    output logic            decReady,
    input  wire logic [3:0] decNibble,
    input  wire logic       decSymMsb,
    input  wire logic       decErr,
    input  wire logic       decFrameEnd,
    // Management frame address check
    input  wire logic [2:0] mgmtFrameAddr,
    output logic            mgmtAddrHit,
    // Captured configuration
    output logic            rmiiMode,
    output logic [2:0]      mgmtAddr,
    output logic [2:0]      opMode,
    // Receive pins
    output logic            rxClk,
    output logic [3:0]      rxData,
    output logic            rx_symbol_msb,
    output logic            rxDataValid,
    output logic            carrierSense,
    output logic            collision,
    output logic            crsDataValid
);
    import mrp_pkg::*;

    // Strap word layout: {iface, mode[2:0], addr[2:0]}
    localparam int STRAP_IFACE = 6;
    localparam int MODE_LSB    = 3;
    localparam int ADDR_LSB    = 0;
    localparam int FIELD_W     = 3;

    // Delimiter hunt for RMII at 10 Mb/s
    typedef enum logic [0:0] {
        SFD_HUNT  = 1'b0,
        SFD_FOUND = 1'b1
    } mrp_sfd_e;

    // Last divider count of a half period at the given link speed
    function automatic logic [3:0] halfLast(input logic fast);
        logic [3:0] half;
        half = fast ? HALF_100 : HALF_10;
        return half - 4'h1;
    endfunction

    logic [6:0]        strapVal;
    logic              strapDone;
    logic [6:0]        syncIn_q;
    logic [6:0]        sync_q;
    logic              fifoValid;
    logic              fifoPop;
    logic [WORD_W-1:0] fifoWord;
    logic [WORD_W-1:0] inWord;
    logic              linkSpd;
    logic              linkFd;
    logic              symMode;
    logic              txAct;
    logic              medAct;
    logic              crsIn;
    logic              colIn;
    logic [3:0]        clkCnt_q;
    logic              rxClk_q;
    logic              clkFall;
    logic              frameErr_q;
    mrp_sfd_e          sfdState_q;
    logic              lowHalf_q;
    logic              slot;
    logic [3:0]        prevNib_q;
    logic [3:0]        rxData_q;
    logic              rxSym_q;
    logic              rxDv_q;
    logic              crs_q;
    logic              col_q;
    logic              crsDv_q;
    logic              echoBlock;
    logic              hold10;

    mrp_strap_latch u_straps (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .strapPins ({iface_select_strap,
                     opmode_strap_bit2, opmode_strap_bit1, opmode_strap_bit0,
                     mgmt_addr_strap_bit2, mgmt_addr_strap_bit1,
                     mgmt_addr_strap_bit0}),
        .strapVal  (strapVal),
        .strapDone (strapDone)
    );

    assign rmiiMode = (strapVal[STRAP_IFACE] == IFACE_RMII);
    assign mgmtAddr = strapVal[ADDR_LSB +: FIELD_W];
    assign opMode   = strapVal[MODE_LSB +: FIELD_W];
    // No hit before capture: the address is not known until then
    assign mgmtAddrHit = strapDone && (mgmtFrameAddr == mgmtAddr);

    // Status levels come from the analog side, so synchronise them
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            syncIn_q <= '0;
            sync_q   <= '0;
        end else begin
            syncIn_q <= {linkSpeed100, fullDuplex, symbolMode, txActive,
                         mediumActive, carrierDet, collisionDet};
            sync_q   <= syncIn_q;
        end
    end
    assign {linkSpd, linkFd, symMode, txAct, medAct, crsIn, colIn} = sync_q;

    // Word layout follows WORD_ERR and WORD_SYM of the package
    assign inWord = {decErr, decSymMsb, decNibble};

    // Sixteen words let the decoder burst ahead of the slower pins
    mrp_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .inValid  (decValid),
        .inReady  (decReady),
        .inData   (inWord),
        .outValid (fifoValid),
        .outReady (fifoPop),
        .outData  (fifoWord)
    );

    // Receive clock divider; output changes land on its falling edge
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            clkCnt_q <= '0;
            rxClk_q  <= 1'b0;
        end else if (clkCnt_q >= halfLast(linkSpd)) begin
            clkCnt_q <= '0;
            rxClk_q  <= ~rxClk_q;
        end else begin
            clkCnt_q <= clkCnt_q + 4'h1;
        end
    end
    // A count left past the end by a speed change wraps at once, so no
    // half period of the receive clock is ever stretched
    assign clkFall = rxClk_q && (clkCnt_q >= halfLast(linkSpd));
    // At 40 MHz the 100 Mb/s clock is 20 MHz: the nearest integer divide
    assign rxClk = rmiiMode ? 1'b0 : rxClk_q;

    // Own transmit is not echoed in RMII 10 Mb/s half duplex
    assign echoBlock = rmiiMode && !linkSpd && !linkFd && txAct;
    assign hold10    = rmiiMode && !linkSpd &&
                       (sfdState_q == SFD_HUNT);
    // A slot is one receive clock period. MII takes a nibble per slot;
    // RMII spends two slots on a word, bits [1:0] first, and pops after
    // the second. Echoed words are dropped one per slot.
    assign slot      = fifoValid && clkFall;
    assign fifoPop   = slot && (echoBlock || !rmiiMode || lowHalf_q);

    // Dibit phase for RMII; a quiet medium or an echo realigns to the
    // low half, so the next word always starts with bits [1:0]
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            lowHalf_q <= 1'b0;
        end else if (!medAct) begin
            lowHalf_q <= 1'b0;
        end else if (slot && rmiiMode) begin
            lowHalf_q <= echoBlock ? 1'b0 : ~lowHalf_q;
        end
    end

    // Delimiter hunt: the last nibble and the one now in the low half
    // form the byte, low nibble first
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sfdState_q <= SFD_HUNT;
            prevNib_q  <= NIBBLE_IDLE;
        end else if (!medAct) begin
            sfdState_q <= SFD_HUNT;
        end else if (slot && rmiiMode && !lowHalf_q) begin
            prevNib_q <= fifoWord[3:0];
            case (sfdState_q)
                SFD_HUNT: begin
                    if ({fifoWord[3:0], prevNib_q} == SFD_BYTE) begin
                        sfdState_q <= SFD_FOUND;
                    end
                end
                SFD_FOUND: begin
                    sfdState_q <= SFD_FOUND;
                end
                default: begin
                    sfdState_q <= SFD_HUNT;
                end
            endcase
        end
    end

    // Error stays up for the rest of the frame once seen
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            frameErr_q <= 1'b0;
        end else if (fifoPop && fifoWord[WORD_ERR]) begin
            frameErr_q <= 1'b1;
        end else if (decFrameEnd || !medAct) begin
            frameErr_q <= 1'b0;
        end
    end

    // Line status pins move on the clock's fall like the data, so the
    // controller sees them settled at its rising edge
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            crs_q   <= 1'b0;
            col_q   <= 1'b0;
            crsDv_q <= 1'b0;
        end else if (clkFall) begin
            crs_q   <= !rmiiMode && crsIn;
            col_q   <= !rmiiMode && colIn;
            crsDv_q <= rmiiMode && medAct && !echoBlock;
        end
    end

    // Data pins, all registered; an empty slot shows idle lines
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxData_q <= NIBBLE_IDLE;
            rxSym_q  <= 1'b0;
            rxDv_q   <= 1'b0;
        end else if (clkFall) begin
            if (slot && !echoBlock) begin
                rxDv_q <= !hold10;
                if (!rmiiMode) begin
                    rxData_q <= fifoWord[3:0];
                end else if (hold10) begin
                    rxData_q <= NIBBLE_IDLE;
                end else if (lowHalf_q) begin
                    rxData_q <= {DIBIT_IDLE, fifoWord[3:2]};
                end else begin
                    rxData_q <= {DIBIT_IDLE, fifoWord[1:0]};
                end
                if (symMode && !rmiiMode) begin
                    rxSym_q <= fifoWord[WORD_SYM];
                end else begin
                    rxSym_q <= frameErr_q || fifoWord[WORD_ERR];
                end
            end else begin
                rxDv_q   <= 1'b0;
                rxData_q <= NIBBLE_IDLE;
                rxSym_q  <= symMode ? 1'b0 : frameErr_q;
            end
        end
    end

    // is the controller's concern; error is driven anyway outside symbol mode
    assign rxData        = rxData_q;
    assign rx_symbol_msb = rxSym_q;
    assign rxDataValid   = rxDv_q;
    assign carrierSense  = crs_q;
    assign collision     = col_q;
    assign crsDataValid  = crsDv_q;
endmodule // mrp_rx_port

//--- tb/mrp_rx_port_chk.sv
`timescale 1ns/1ps
module mrp_rx_port_chk
    import mrp_pkg::*;
(
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       arst_n,
    // Link state
    input wire logic       linkSpeed100,
    input wire logic       fullDuplex,
    input wire logic       txActive,
    input wire logic       collisionDet,
    // Configuration
    input wire logic [2:0] mgmtFrameAddr,
    input wire logic       mgmtAddrHit,
    input wire logic       rmiiMode,
    input wire logic [2:0] mgmtAddr,
    // Receive pins
    input wire logic       rxClk,
    input wire logic [3:0] rxData,
    input wire logic       rxDataValid,
    input wire logic       collision,
    input wire logic       crsDataValid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic [4:0] upCnt_q, runCnt_q, echoCnt_q, colCnt_q;
    wire echoOn = rmiiMode && !linkSpeed100 && !fullDuplex && txActive;
    wire colOn = !rmiiMode && collisionDet;
    // Saturating counters keep long waits out of the properties
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            {upCnt_q, runCnt_q, echoCnt_q, colCnt_q} <= '0;
        end else begin
            upCnt_q <= upCnt_q + 5'(upCnt_q != 5'h1F);
            runCnt_q <= $stable(rxClk) ? runCnt_q + 5'(runCnt_q != 5'h1F) : '0;
            echoCnt_q <= echoOn ? echoCnt_q + 5'(echoCnt_q != 5'h1F) : '0;
            colCnt_q <= colOn ? colCnt_q + 5'(colCnt_q != 5'h1F) : '0;
        end
    end
    a_rmii_upper_idle: assert property (
        rmiiMode |-> rxData[3:2] == 2'h0) else $error("upper lines busy");
    a_rmii_clk_still: assert property (
        rmiiMode [*3] |-> !rxClk) else $error("clock runs in RMII");
    a_addr_match: assert property (
        mgmtAddrHit |-> mgmtFrameAddr == mgmtAddr) else $error("bad hit");
    a_straps_held: assert property (
        upCnt_q > 5'h05 |-> $stable({rmiiMode, mgmtAddr}))
        else $error("strap value moved");
    a_clk_half_max: assert property (
        !rmiiMode && upCnt_q > 5'h14 |-> runCnt_q < HALF_10_CYC)
        else $error("receive clock half period too long");
    a_pins_on_fall: assert property (
        !rmiiMode && ($changed(rxData) || $changed(rxDataValid))
        |-> $fell(rxClk)) else $error("pins moved off clock fall");
    a_no_echo: assert property (
        echoCnt_q > 5'h18 |-> !crsDataValid) else $error("echo seen");
    a_col_follow: assert property (
        colCnt_q > 5'h18 |-> collision) else $error("collision missed");
    c_mii_word: cover property (!rmiiMode && rxDataValid);
    c_rmii_busy: cover property (rmiiMode && crsDataValid);
    c_addr_hit: cover property (mgmtAddrHit);
endmodule // mrp_rx_port_chk

bind mrp_rx_port mrp_rx_port_chk mrp_rx_port_chk_inst (.*);

//--- tb/mrp_mac_model.sv
`timescale 1ns/1ps
module mrp_mac_model (
    // Receive pins as the controller sees them
    input wire logic       rxClk,
    input wire logic [3:0] rxData,
    input wire logic       rx_symbol_msb,
    input wire logic       rxDataValid,
    input wire logic       rmiiMode
);
    // Words taken on the rising receive clock, {fifth line, nibble}
    logic [4:0] got[$];
    // Only MII words are gathered; RMII use never leans on the error pin
    always @(posedge rxClk) begin
        if (rxDataValid === 1'b1 && !rmiiMode)
            got.push_back({rx_symbol_msb, rxData});
    end
endmodule // mrp_mac_model

//--- tb/test_mrp_rx_port.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
    n_fail++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module test_mrp_rx_port;
    import mrp_pkg::*;
    logic       sys_clk = 1'b0;
    logic       arst_n, decReady, mgmtAddrHit, rmiiMode, rxClk, rxDataValid;
    logic       linkSpeed100, fullDuplex, symbolMode, txActive, decErr;
    logic       mediumActive, carrierDet, collisionDet, decFrameEnd;
    logic       decValid, decSymMsb, rx_symbol_msb, carrierSense, collision;
    logic       crsDataValid, ok, seen, seenHi, full, prevClk;
    logic [6:0] straps;
    logic [3:0] decNibble, rxData;
    logic [2:0] mgmtFrameAddr, mgmtAddr, opMode;
    logic [4:0] expQ[$];
    int         n_fail = 0, total_checks = 0, cnt;

    always #12.5 sys_clk = ~sys_clk;
    // Straps are {iface, mode[2:0], addr[2:0]}
    mrp_rx_port #(.DEPTH(FIFO_DEPTH)) mrp_rx_port_inst (.*,
        .iface_select_strap(straps[6]), .opmode_strap_bit2(straps[5]),
        .opmode_strap_bit1(straps[4]), .opmode_strap_bit0(straps[3]),
        .mgmt_addr_strap_bit2(straps[2]), .mgmt_addr_strap_bit1(straps[1]),
        .mgmt_addr_strap_bit0(straps[0]));
    mrp_mac_model mrp_mac_model_inst (.*);

    function automatic logic [4:0] macW(input int k);
        return mrp_mac_model_inst.got[k];
    endfunction
    function automatic int macN();
        return mrp_mac_model_inst.got.size();
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic do_reset(input logic [6:0] s);
        straps = s;
        arst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        cyc(1);
        arst_n = 1'b1;
        cyc(6);
    endtask
    // One offer; ok says whether the coming edge takes the word
    task automatic push(input logic [3:0] nb, input logic sm, er);
        {decValid, decNibble, decSymMsb, decErr} = {1'b1, nb, sm, er};
        ok = decReady;
        cyc(1);
    endtask
    task automatic send(input logic [3:0] nb, input logic sm, er);
        ok = 1'b0;
        for (int t = 0; t < 400 && !ok; t++) push(nb, sm, er);
        decValid = 1'b0;
        cyc(1);
    endtask
    task automatic see(input logic sm, er, exp);
        mrp_mac_model_inst.got.delete();
        send(4'h3, sm, er);
        cyc(24);
        `CHK("symPin", {1'b1, exp}, {macN() == 1, macW(0) >= 5'h10})
    endtask
    task automatic watch(input int n);
        seen = 1'b0;
        seenHi = 1'b0;
        repeat (n) begin
            @(negedge sys_clk);
            if (rxData[1:0] !== 2'h0) seen = 1'b1;
            if (rxData[1:0] === 2'h1) seenHi = 1'b1;
        end
    endtask
    task automatic test_done();
        if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        {linkSpeed100, fullDuplex, symbolMode, txActive} = 4'h0;
        {mediumActive, carrierDet, collisionDet, decFrameEnd} = 4'h0;
        {decValid, decSymMsb, decErr, decNibble, mgmtFrameAddr} = 10'h000;
        do_reset(7'h35);
        `CHK("cfg", 7'h35, {rmiiMode, opMode, mgmtAddr})
        mgmtFrameAddr = 3'h5;
        cyc(1);
        `CHK("hit", 1'b1, mgmtAddrHit)
        mgmtFrameAddr = 3'h2;
        cyc(1);
        `CHK("miss", 1'b0, mgmtAddrHit)
        straps = 7'h4A;
        cyc(8);
        `CHK("held", 7'h35, {rmiiMode, opMode, mgmtAddr})
        for (int sp = 0; sp < 2; sp++) begin
            linkSpeed100 = sp[0];
            cyc(4);
            mrp_mac_model_inst.got.delete();
            expQ.delete();
            full = 1'b0;
            for (int i = 0; i < 20; i++) begin
                push(i[3:0], 1'b0, 1'b0);
                if (ok) expQ.push_back({1'b0, i[3:0]});
                else full = 1'b1;
            end
            decValid = 1'b0;
            cyc(400);
            `CHK("full", sp == 0, full)
            `CHK("count", expQ.size(), macN())
            foreach (expQ[j]) `CHK("nib", expQ[j], macW(j))
            prevClk = rxClk;
            cnt = 0;
            repeat (160) begin
                @(negedge sys_clk);
                cnt += int'(rxClk && !prevClk);
                prevClk = rxClk;
            end
            `CHK("rises", 80 / int'(sp ? HALF_100 : HALF_10), cnt)
        end
        mediumActive = 1'b1;
        cyc(4);
        see(1'b1, 1'b0, 1'b0);
        see(1'b0, 1'b1, 1'b1);
        see(1'b0, 1'b0, 1'b1);
        decFrameEnd = 1'b1;
        cyc(1);
        {decFrameEnd, symbolMode} = 2'h1;
        cyc(4);
        see(1'b1, 1'b0, 1'b1);
        see(1'b0, 1'b1, 1'b0);
        {carrierDet, collisionDet} = 2'h3;
        cyc(40);
        `CHK("crsCol", 2'h3, {carrierSense, collision})
        {carrierDet, collisionDet, symbolMode} = 3'h0;
        cyc(40);
        `CHK("crsCol", 2'h0, {carrierSense, collision})
        {mediumActive, linkSpeed100} = 2'h0;
        do_reset(7'h5A);
        `CHK("cfg", 7'h5A, {rmiiMode, opMode, mgmtAddr})
        mediumActive = 1'b1;
        cyc(40);
        `CHK("crsDv", 1'b1, crsDataValid)
        repeat (4) send(4'h5, 1'b0, 1'b0);
        watch(120);
        `CHK("preamble", 1'b0, seen)
        send(SFD_BYTE[3:0], 1'b0, 1'b0);
        send(SFD_BYTE[7:4], 1'b0, 1'b0);
        send(4'h6, 1'b0, 1'b0);
        watch(200);
        `CHK("payload", 1'b1, seen)
        `CHK("upperDibit", 1'b1, seenHi)
        txActive = 1'b1;
        repeat (2) send(4'h6, 1'b0, 1'b0);
        cyc(40);
        `CHK("echo", 1'b0, crsDataValid)
        {txActive, mediumActive} = 2'h0;
        cyc(40);
        `CHK("idle", 1'b0, crsDataValid)
        test_done();
    end

    // Whole run is under two thousand cycles; this bound is far beyond it
    initial begin
        #250000;
        n_fail++;
        test_done();
    end
endmodule // test_mrp_rx_port
